// ---- verilog/lnsc_pkg.sv ----
/*
  Shared constants for the loop node switch and counter block: register
  offsets, field positions, reset values, mode and channel codes, timings.
  Assumes a single 100 MHz node clock and a synchronous active-high reset.
*/
package lnsc_pkg;

    // clock and timings
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned FLASH_HALF_MS    = 250;
    localparam int unsigned FLASH_HALF_CYC   = FLASH_HALF_MS * 1000 * CLK_MHZ;
    localparam int unsigned ERR_WINDOW_MS    = 10;
    localparam int unsigned ERR_WINDOW_CYC   = ERR_WINDOW_MS * 1000 * CLK_MHZ;
    localparam logic [7:0]  ERR_THRESHOLD    = 8'h10;

    // counter memory
    localparam int unsigned CNT_DEPTH        = 256;
    localparam logic [7:0]  CNT_MSG_TX_IDX   = 8'h30;
    localparam logic [7:0]  CNT_RESET_VAL    = 8'h00;

    // register byte offsets
    localparam logic [7:0]  REG_STATUS       = 8'h00;
    localparam logic [7:0]  REG_IRQ_STATUS   = 8'h04;
    localparam logic [7:0]  REG_IRQ_MASK     = 8'h08;
    localparam logic [7:0]  REG_CTRL         = 8'h0c;
    localparam logic [7:0]  REG_CNT_INDEX    = 8'h10;
    localparam logic [7:0]  REG_CNT_DATA     = 8'h14;

    // status register fields
    localparam int unsigned ST_ADDR_LSB      = 0;
    localparam int unsigned ST_MODE_LSB      = 8;
    localparam int unsigned ST_CHA_EN_BIT    = 12;
    localparam int unsigned ST_CHB_EN_BIT    = 13;
    localparam int unsigned ST_FLASH_BIT     = 14;

    // interrupt status / mask layout
    localparam int unsigned IRQ_CHA_OFF_BIT  = 0;
    localparam int unsigned IRQ_CHB_OFF_BIT  = 1;
    localparam int unsigned IRQ_WRAP_BIT     = 2;
    localparam int unsigned IRQ_WIDTH        = 3;
    localparam logic [2:0]  IRQ_MASK_RESET   = 3'h0;

    // control register fields
    localparam int unsigned CTRL_CLEAR_BIT   = 0;

    // address switch mode poles (after polarity fix, pole 1 = bit 7)
    localparam logic [1:0]  MODE_POLES_NORMAL  = 2'h0;
    localparam logic [1:0]  MODE_POLES_MONITOR = 2'h2;

    typedef enum logic [2:0] {
        MODE_NORMAL  = 3'b001,
        MODE_MONITOR = 3'b010,
        MODE_TEST    = 3'b100
    } lnsc_mode_t;

    typedef enum logic [2:0] {
        CH_BOTH_ON = 3'b001,
        CH_A_OFF   = 3'b010,
        CH_B_OFF   = 3'b100
    } lnsc_chan_t;

endpackage

// ---- verilog/lnsc_err_window.sv ----
/*
  Error-rate window for one incoming loop channel: counts receive errors
  inside a fixed interval and pulses when the count reaches a threshold.
  Assumes rx_error_i is a one-cycle pulse synchronous to clock_i.
*/
module lnsc_err_window #(
    parameter int unsigned INTERVAL_CYC = 1000,
    parameter logic [7:0]  THRESHOLD    = 8'h10
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic enable_i,
    input  wire logic rx_error_i,
    output logic      excessive_o
);
    import lnsc_pkg::*;

    logic [31:0] win_reg;
    logic [7:0]  err_reg;
    logic        win_end;
    logic        trip;

    assign win_end = (win_reg == 32'(INTERVAL_CYC - 1));
    assign trip    = enable_i && rx_error_i && (err_reg == THRESHOLD - 8'h01);

    // interval timer, held at zero while idle
    always_ff @(posedge clock_i) begin
        if (rst_i || !enable_i || win_end) begin
            win_reg <= 32'h0;
        end else begin
            win_reg <= win_reg + 32'h1;
        end
    end

    // errors in the current interval; restarts on each interval or trip
    always_ff @(posedge clock_i) begin
        if (rst_i || !enable_i || win_end || trip) begin
            err_reg <= 8'h00;
        end else if (rx_error_i) begin
            err_reg <= err_reg + 8'h01;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            excessive_o <= 1'b0;
        end else begin
            excessive_o <= trip;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_trip_at_threshold: assert property (
        (enable_i && rx_error_i && !win_end && err_reg == THRESHOLD - 8'h01) |=> excessive_o)
        else $error("threshold reached but no excessive pulse");
    a_no_trip_below: assert property (
        (err_reg < THRESHOLD - 8'h01) |=> !excessive_o)
        else $error("excessive pulse below threshold");
endmodule

// ---- verilog/lnsc_top.sv ----
/*
  Loop node switch decode, counter memory, lamp display and channel
  error-rate monitor with a small register port and one interrupt.
  Assumes all inputs synchronous to clock_i; switch inputs are contact
  closures (1 = pole closed); rst_i comes from the paired bus unit.
*/
module lnsc_top #(
    parameter int unsigned FLASH_HALF_CYC = lnsc_pkg::FLASH_HALF_CYC,
    parameter int unsigned ERR_WINDOW_CYC = lnsc_pkg::ERR_WINDOW_CYC,
    parameter logic [7:0]  ERR_THRESHOLD  = lnsc_pkg::ERR_THRESHOLD
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] counter_select_switch_closed_i,
    input  wire logic [7:0] node_address_switch_closed_i,
    input  wire logic       event_valid_i,
    input  wire logic [7:0] event_index_i,
    input  wire logic       msg_tx_i,
    input  wire logic       rx_error_a_i,
    input  wire logic       rx_error_b_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic [31:0]     reg_rdata_o,
    output logic [7:0]      lamp_o,
    output logic [5:0]      node_address_o,
    output logic            chan_a_enable_o,
    output logic            chan_b_enable_o,
    output logic            monitor_active_o,
    output logic            irq_o
);
    import lnsc_pkg::*;

    logic [7:0]     sel_reg;
    logic [7:0]     addr_sw_reg;
    lnsc_mode_t     mode_reg;
    lnsc_mode_t     mode_next;
    lnsc_chan_t     chan_reg;
    lnsc_chan_t     chan_next;
    logic [7:0]     cnt_mem [CNT_DEPTH];
    logic [CNT_DEPTH-1:0] wrap_vec;
    logic           any_wrap;
    logic           clear_cnt;
    logic           flash_reg;
    logic           phase_reg;
    logic [31:0]    blink_reg;
    logic [7:0]     sel_byte;
    logic           excess_a;
    logic           excess_b;
    logic           mon_en;
    logic [IRQ_WIDTH-1:0] irq_stat_reg;
    logic [IRQ_WIDTH-1:0] irq_mask_reg;
    logic [IRQ_WIDTH-1:0] irq_set;
    logic [7:0]     cnt_index_reg;
    logic           wr_irq_stat;

    // switch poles: open reads 1, so invert the closures; pole 1 is bit 7
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sel_reg     <= 8'h00;
            addr_sw_reg <= 8'h00;
        end else begin
            sel_reg     <= ~counter_select_switch_closed_i;
            addr_sw_reg <= ~node_address_switch_closed_i;
        end
    end

    // node address from poles 3..8, pole 3 weighs 32
    // range 1..63 and uniqueness are the installer's job, not checked here
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            node_address_o <= 6'h00;
        end else begin
            node_address_o <= addr_sw_reg[5:0];
        end
    end

    // mode from poles 1 and 2; other codes are test settings and run unmonitored
    always_comb begin
        unique case (addr_sw_reg[7:6])
            MODE_POLES_NORMAL:  mode_next = MODE_NORMAL;
            MODE_POLES_MONITOR: mode_next = MODE_MONITOR;
            default:            mode_next = MODE_TEST;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mode_reg <= MODE_NORMAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // windows only run in monitor mode and while both channels are up
    assign mon_en = (mode_reg == MODE_MONITOR) && (chan_reg == CH_BOTH_ON);

    lnsc_err_window #(
        .INTERVAL_CYC (ERR_WINDOW_CYC),
        .THRESHOLD    (ERR_THRESHOLD)
    ) u_win_a (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .enable_i    (mon_en),
        .rx_error_i  (rx_error_a_i),
        .excessive_o (excess_a)
    );

    lnsc_err_window #(
        .INTERVAL_CYC (ERR_WINDOW_CYC),
        .THRESHOLD    (ERR_THRESHOLD)
    ) u_win_b (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .enable_i    (mon_en),
        .rx_error_i  (rx_error_b_i),
        .excessive_o (excess_b)
    );

    // channel shutdown; a shut channel stays shut until reset, and a tie
    // goes to channel a so the other one always survives
    always_comb begin
        chan_next = chan_reg;
        unique case (chan_reg)
            CH_BOTH_ON: begin
                if (mode_reg == MODE_MONITOR && excess_a) begin
                    chan_next = CH_A_OFF;
                end else if (mode_reg == MODE_MONITOR && excess_b) begin
                    chan_next = CH_B_OFF;
                end
            end
            CH_A_OFF: chan_next = CH_A_OFF;
            CH_B_OFF: chan_next = CH_B_OFF;
            default:  chan_next = CH_BOTH_ON;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            chan_reg <= CH_BOTH_ON;
        end else begin
            chan_reg <= chan_next;
        end
    end

    assign chan_a_enable_o  = (chan_reg != CH_A_OFF);
    assign chan_b_enable_o  = (chan_reg != CH_B_OFF);
    assign monitor_active_o = (mode_reg == MODE_MONITOR);

    // flashing latches once a channel is shut and only reset clears it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            flash_reg <= 1'b0;
        end else if (chan_reg != CH_BOTH_ON) begin
            flash_reg <= 1'b1;
        end
    end

    // blink timer; free of the switches so the rate never changes
    always_ff @(posedge clock_i) begin
        if (rst_i || !flash_reg) begin
            blink_reg <= 32'h0;
            phase_reg <= 1'b0;
        end else if (blink_reg == 32'(FLASH_HALF_CYC - 1)) begin
            blink_reg <= 32'h0;
            phase_reg <= !phase_reg;
        end else begin
            blink_reg <= blink_reg + 32'h1;
        end
    end

    // software clear of all counters, a one-cycle write strobe
    assign clear_cnt = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_CLEAR_BIT];

    // counter memory: one byte per location, wraps at 8'hff
    // 8'h30 additionally counts transmitted messages
    for (genvar i = 0; i < CNT_DEPTH; i++) begin : g_cnt
        logic       hit_ev;
        logic       hit_tx;
        logic [7:0] step;
        assign hit_ev = event_valid_i && (event_index_i == 8'(i));
        assign hit_tx = msg_tx_i && (CNT_MSG_TX_IDX == 8'(i));
        assign step   = {7'h00, hit_ev} + {7'h00, hit_tx};
        assign wrap_vec[i] = (hit_ev || hit_tx) && (9'(cnt_mem[i]) + 9'(step) > 9'h0ff);
        always_ff @(posedge clock_i) begin
            if (rst_i || clear_cnt) begin
                cnt_mem[i] <= CNT_RESET_VAL;
            end else begin
                cnt_mem[i] <= cnt_mem[i] + step;
            end
        end
    end

    assign any_wrap = |wrap_vec;

    // lamps show the selected byte, blanked on the dark half while flashing
    assign sel_byte = cnt_mem[sel_reg];
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lamp_o <= 8'h00;
        end else if (flash_reg && phase_reg) begin
            lamp_o <= 8'h00;
        end else begin
            lamp_o <= sel_byte;
        end
    end

    // interrupt events: channel shut and any counter wrapping
    assign irq_set[IRQ_CHA_OFF_BIT] = (chan_reg == CH_BOTH_ON) && (chan_next == CH_A_OFF);
    assign irq_set[IRQ_CHB_OFF_BIT] = (chan_reg == CH_BOTH_ON) && (chan_next == CH_B_OFF);
    assign irq_set[IRQ_WRAP_BIT]    = any_wrap;
    assign wr_irq_stat = reg_wr_i && (reg_addr_i == REG_IRQ_STATUS);

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
        end else if (wr_irq_stat) begin
            irq_stat_reg <= (irq_stat_reg & ~reg_wdata_i[IRQ_WIDTH-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    // software-owned registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_mask_reg  <= IRQ_MASK_RESET;
            cnt_index_reg <= 8'h00;
        end else if (reg_wr_i) begin
            if (reg_addr_i == REG_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata_i[IRQ_WIDTH-1:0];
            end
            if (reg_addr_i == REG_CNT_INDEX) begin
                cnt_index_reg <= reg_wdata_i[7:0];
            end
        end
    end

    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    // read data stands only in the cycle after the strobe; unmapped reads 0
    always_ff @(posedge clock_i) begin
        if (rst_i || !reg_rd_i) begin
            reg_rdata_o <= 32'h0;
        end else begin
            unique case (reg_addr_i)
                REG_STATUS: begin
                    reg_rdata_o <= 32'h0;
                    reg_rdata_o[ST_ADDR_LSB +: 6] <= node_address_o;
                    reg_rdata_o[ST_MODE_LSB +: 3] <= mode_reg;
                    reg_rdata_o[ST_CHA_EN_BIT]    <= chan_a_enable_o;
                    reg_rdata_o[ST_CHB_EN_BIT]    <= chan_b_enable_o;
                    reg_rdata_o[ST_FLASH_BIT]     <= flash_reg;
                end
                REG_IRQ_STATUS: reg_rdata_o <= {29'h0, irq_stat_reg};
                REG_IRQ_MASK:   reg_rdata_o <= {29'h0, irq_mask_reg};
                REG_CNT_INDEX:  reg_rdata_o <= {24'h0, cnt_index_reg};
                REG_CNT_DATA:   reg_rdata_o <= {24'h0, cnt_mem[cnt_index_reg]};
                default:        reg_rdata_o <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // a channel leaves the both-on state
    sequence s_shut;
        (chan_reg == CH_BOTH_ON) ##1 (chan_reg != CH_BOTH_ON);
    endsequence

    // last cycle of a flash half period
    sequence s_half_end;
        flash_reg && (blink_reg == 32'(FLASH_HALF_CYC - 1));
    endsequence

    // lamps and counters
    a_lamp_shows_sel: assert property (
        !flash_reg |=> lamp_o == $past(sel_byte))
        else $error("lamps do not show the selected counter");

    a_default_msg_count: assert property (
        (!flash_reg && sel_reg == CNT_MSG_TX_IDX) |=> lamp_o == $past(cnt_mem[CNT_MSG_TX_IDX]))
        else $error("setting 30 does not show message count");

    a_counter_step: assert property (
        (event_valid_i && !msg_tx_i && !clear_cnt)
        |=> cnt_mem[$past(event_index_i)] == $past(cnt_mem[event_index_i]) + 8'h01)
        else $error("counter did not step by one");

    a_counter_clear: assert property (
        clear_cnt |=> cnt_mem[CNT_MSG_TX_IDX] == CNT_RESET_VAL)
        else $error("counter clear missed");

    a_wrap_flag: assert property (
        irq_set[IRQ_WRAP_BIT] |=> irq_stat_reg[IRQ_WRAP_BIT])
        else $error("counter wrap not flagged");

    // two stages from pin to address, so edges just after reset are skipped
    a_address_poles: assert property (
        (!$past(rst_i) && !$past(rst_i, 2))
        |-> node_address_o == ~$past(node_address_switch_closed_i[5:0], 2))
        else $error("node address does not follow poles 3 to 8");

    // channel monitor
    a_normal_no_shut: assert property (
        (mode_reg == MODE_NORMAL && chan_reg == CH_BOTH_ON) |=> chan_reg == CH_BOTH_ON)
        else $error("channel shut outside monitor mode");

    a_monitor_shut_a: assert property (
        (mode_reg == MODE_MONITOR && chan_reg == CH_BOTH_ON && excess_a)
        |=> !chan_a_enable_o && chan_b_enable_o)
        else $error("excessive channel a not shut");

    a_monitor_shut_b: assert property (
        (mode_reg == MODE_MONITOR && chan_reg == CH_BOTH_ON && excess_b && !excess_a)
        |=> chan_a_enable_o && !chan_b_enable_o)
        else $error("excessive channel b not shut");

    a_never_both_off: assert property (
        chan_a_enable_o || chan_b_enable_o)
        else $error("both channels shut");

    a_shut_held: assert property (
        (chan_reg != CH_BOTH_ON) |=> $stable(chan_reg))
        else $error("shut channel reopened before reset");

    // flashing
    a_flash_sticky: assert property (
        s_shut |=> flash_reg [*8])
        else $error("flashing did not start and persist after shutdown");

    a_dark_half: assert property (
        (flash_reg && phase_reg) |=> lamp_o == 8'h00)
        else $error("lamps lit on the dark half");

    a_phase_turn: assert property (
        s_half_end |=> phase_reg != $past(phase_reg))
        else $error("flash phase did not turn");

    // register port: read data only right after a read strobe
    a_rdata_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside a read");
endmodule

// ---- tb/lnsc_loop_chan_model.sv ----
/*
  Far-side model of the two incoming loop channels: sends bursts of
  receive-error pulses on one chosen channel at a chosen spacing.
  Assumes the bench clock and a synchronous active-high reset.
*/
module lnsc_loop_chan_model (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       chan_b_i,
    input  wire logic [7:0] count_i,
    input  wire logic [3:0] gap_i,
    output logic            rx_error_a_o,
    output logic            rx_error_b_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] left_reg;
    logic [3:0] gap_reg;
    logic [3:0] space_reg;
    logic       on_b_reg;

    // burst sequencer; gap 0 gives an error every cycle, the harshest line
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            left_reg  <= 8'h00;
            gap_reg   <= 4'h0;
            space_reg <= 4'h0;
            on_b_reg  <= 1'b0;
        end else if (start_i && left_reg == 8'h00) begin
            left_reg  <= count_i;
            gap_reg   <= gap_i;
            space_reg <= 4'h0;
            on_b_reg  <= chan_b_i;
        end else if (left_reg != 8'h00) begin
            if (space_reg == 4'h0) begin
                left_reg  <= left_reg - 8'h01;
                space_reg <= gap_reg;
            end else begin
                space_reg <= space_reg - 4'h1;
            end
        end
    end

    // one error per cycle shown, on one channel only
    assign rx_error_a_o = (left_reg != 8'h00) && (space_reg == 4'h0) && !on_b_reg;
    assign rx_error_b_o = (left_reg != 8'h00) && (space_reg == 4'h0) && on_b_reg;
    assign busy_o       = (left_reg != 8'h00);
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the loop node switch block: register tasks,
  event bursts and a channel error model drive the switch decode,
  counters, lamps and channel monitor. Assumes shortened timing params.
*/
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lnsc_pkg::*;

    logic        clock_i    = 1'b0;
    logic        rst_i      = 1'b1;
    logic [7:0]  sel_closed = 8'hff;
    logic [7:0]  adr_closed = 8'hff;
    logic [7:0]  ev_idx     = 8'h00;
    logic [7:0]  reg_addr   = 8'h00;
    logic [7:0]  pm_count   = 8'h00;
    logic [3:0]  pm_gap     = 4'h0;
    logic        ev_valid   = 1'b0;
    logic        msg_tx     = 1'b0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        pm_start   = 1'b0;
    logic        pm_b       = 1'b0;
    logic [31:0] reg_wdata  = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic [7:0]  lamp;
    logic [5:0]  node_addr;
    logic        cha_en, chb_en, mon, irq, err_a, err_b, pm_busy;
    int          failures        = 0;
    int          samples_checked = 0;
    int          dark, lit;
    logic [5:0]  adrs [3] = '{6'h01, 6'h2a, 6'h3f};

    always #5 clock_i = ~clock_i;

    lnsc_top #(.FLASH_HALF_CYC(4), .ERR_WINDOW_CYC(64), .ERR_THRESHOLD(8'h03)) lnsc_top_i (
        .clock_i(clock_i), .rst_i(rst_i), .counter_select_switch_closed_i(sel_closed),
        .node_address_switch_closed_i(adr_closed), .event_valid_i(ev_valid),
        .event_index_i(ev_idx), .msg_tx_i(msg_tx), .rx_error_a_i(err_a),
        .rx_error_b_i(err_b), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .lamp_o(lamp),
        .node_address_o(node_addr), .chan_a_enable_o(cha_en), .chan_b_enable_o(chb_en),
        .monitor_active_o(mon), .irq_o(irq));

    lnsc_loop_chan_model lnsc_loop_chan_model_i (
        .clock_i(clock_i), .rst_i(rst_i), .start_i(pm_start), .chan_b_i(pm_b),
        .count_i(pm_count), .gap_i(pm_gap), .rx_error_a_o(err_a),
        .rx_error_b_o(err_b), .busy_o(pm_busy));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock_i);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge clock_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock_i);
        reg_rd <= 1'b0;
        @(negedge clock_i);
        rd = reg_rdata;
    endtask

    // back-to-back event pulses, one count each cycle
    task automatic events(input logic [7:0] idx, input int n, input logic tx);
        @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            ev_valid <= !tx;
            msg_tx <= tx;
            ev_idx <= idx;
            @(posedge clock_i);
        end
        ev_valid <= 1'b0;
        msg_tx <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask

    task automatic errors(input logic on_b, input logic [7:0] n, input logic [3:0] gap);
        int guard = 0;
        @(posedge clock_i);
        pm_start <= 1'b1;
        pm_b <= on_b;
        pm_count <= n;
        pm_gap <= gap;
        @(posedge clock_i);
        pm_start <= 1'b0;
        @(negedge clock_i);
        while (pm_busy === 1'b1 && guard < 500) begin
            @(negedge clock_i);
            guard++;
        end
        check("error burst finished", 32'h1, {31'h0, guard < 500});
        repeat (4) @(posedge clock_i);
    endtask

    task automatic watch_lamp(input int n);
        dark = 0;
        lit = 0;
        repeat (n) begin
            @(negedge clock_i);
            if (lamp === 8'h00) dark++;
            else lit++;
        end
    endtask

    task automatic set_switch(input logic [7:0] sel_val, input logic [7:0] adr_val);
        @(posedge clock_i);
        sel_closed <= ~sel_val;
        adr_closed <= ~adr_val;
        repeat (4) @(posedge clock_i);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        $display("[ERR] run length expected done seen hang");
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check("lamp", 32'h0, {24'h0, lamp});
        check("enables mon irq", 32'h6, {29'h0, cha_en, chb_en, mon || irq});
        rdr(REG_IRQ_MASK);
        check("mask reset", 32'h0, rd);
        rdr(8'h20);
        check("unmapped read", 32'h0, rd);
        $display("test reset done");
        // address poles 3..8, configured in 1..63 only
        foreach (adrs[i]) begin
            set_switch(8'h00, {2'b00, adrs[i]});
            check("node address", {26'h0, adrs[i]}, {26'h0, node_addr});
            rdr(REG_STATUS);
            check("status addr", {26'h0, adrs[i]}, {26'h0, rd[5:0]});
        end
        for (int m = 0; m < 4; m++) begin
            set_switch(8'h00, {m[1:0], 6'h15});
            rdr(REG_STATUS);
            check("mode", (m == 0) ? 32'h1 : (m == 2) ? 32'h2 : 32'h4, {29'h0, rd[10:8]});
            check("monitor flag", {31'h0, m == 2}, {31'h0, mon});
        end
        $display("test switches done");
        set_switch(CNT_MSG_TX_IDX, 8'h15);
        events(8'h00, 5, 1'b1);
        check("lamp tx count", 32'h5, {24'h0, lamp});
        events(8'h05, 3, 1'b0);
        set_switch(8'h05, 8'h15);
        check("lamp idx 05", 32'h3, {24'h0, lamp});
        events(8'hff, 2, 1'b0);
        set_switch(8'hff, 8'h15);
        check("lamp idx ff", 32'h2, {24'h0, lamp});
        events(8'h07, 257, 1'b0);
        wr(REG_CNT_INDEX, 32'h7);
        rdr(REG_CNT_DATA);
        check("wrapped count", 32'h1, rd);
        @(negedge clock_i);
        check("read data stand", 32'h0, reg_rdata);
        rdr(REG_IRQ_STATUS);
        check("wrap status", 32'h4, rd);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(REG_IRQ_MASK, 32'h4);
        @(negedge clock_i);
        check("irq unmasked", 32'h1, {31'h0, irq});
        wr(REG_IRQ_STATUS, 32'h4);
        @(negedge clock_i);
        check("irq cleared", 32'h0, {31'h0, irq});
        wr(REG_CTRL, 32'h1);
        rdr(REG_CNT_DATA);
        check("count clear", 32'h0, rd);
        $display("test counters done");
        // normal and test modes never shut a channel
        set_switch(CNT_MSG_TX_IDX, 8'h11);
        errors(1'b0, 8'h08, 4'h0);
        check("normal enables", 32'h3, {30'h0, cha_en, chb_en});
        set_switch(CNT_MSG_TX_IDX, 8'h51);
        errors(1'b1, 8'h08, 4'h0);
        check("test mode enables", 32'h3, {30'h0, cha_en, chb_en});
        $display("test unmonitored done");
        set_switch(CNT_MSG_TX_IDX, 8'h91);
        wr(REG_IRQ_MASK, 32'h3);
        events(8'h00, 6, 1'b1);
        errors(1'b0, 8'h02, 4'h3);
        check("below threshold", 32'h3, {30'h0, cha_en, chb_en});
        watch_lamp(20);
        check("steady lamp", 32'h0, dark);
        errors(1'b0, 8'h06, 4'h1);
        check("chan a shut", 32'h1, {30'h0, cha_en, chb_en});
        check("shut irq", 32'h1, {31'h0, irq});
        rdr(REG_IRQ_STATUS);
        check("shut status", 32'h1, rd);
        rdr(REG_STATUS);
        check("status flash", 32'h6, {29'h0, rd[14:12]});
        watch_lamp(32);
        check("flashing", 32'h1, {31'h0, dark > 0 && lit > 0});
        errors(1'b1, 8'h06, 4'h0);
        check("never both shut", 32'h1, {30'h0, cha_en, chb_en});
        wr(REG_IRQ_STATUS, 32'h1);
        watch_lamp(32);
        check("flash persists", 32'h1, {31'h0, dark > 0 && lit > 0});
        check("irq after clear", 32'h0, {31'h0, irq});
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check("enables after reset", 32'h3, {30'h0, cha_en, chb_en});
        events(8'h00, 2, 1'b1);
        watch_lamp(20);
        check("no flash after reset", 32'h0, dark);
        wr(REG_IRQ_MASK, 32'h3);
        errors(1'b1, 8'h06, 4'h0);
        check("chan b shut", 32'h2, {30'h0, cha_en, chb_en});
        rdr(REG_IRQ_STATUS);
        check("b shut status", 32'h2, rd);
        $display("test monitor done");
        give_verdict();
    end
endmodule
